// ===== rtl/uhpia_defs.vh
// Constants of the host port idle and attach sequencer
`ifndef UHPIA_DEFS_VH
`define UHPIA_DEFS_VH

// ==========================================
// Register addresses
`define UHPIA_ADDR_W 4
`define UHPIA_A_CMD 4'h0
`define UHPIA_A_MON 4'h1
`define UHPIA_A_XCVR 4'h2
`define UHPIA_A_EVT 4'h3
`define UHPIA_A_EVT_EN 4'h4
`define UHPIA_A_EVT_CLR 4'h5

// ==========================================
// Command register fields
`define UHPIA_CMD_CANCEL_BIT 7
`define UHPIA_CMD_FIELD_W 4
`define UHPIA_CMD_GO_IDLE 4'h1
`define UHPIA_CMD_GO_WAIT_DEF 4'h3
`define UHPIA_CMD_NONE 4'h0

// ==========================================
// Monitor encodings
`define UHPIA_MON_IDLE 3'h0
`define UHPIA_MON_WAIT 3'h1

// ==========================================
// Transceiver encodings
`define UHPIA_SEL_HS 2'h0
`define UHPIA_SEL_FS 2'h1
`define UHPIA_SEL_LS 2'h2
`define UHPIA_OP_NORMAL 2'h0
`define UHPIA_OP_NONDRV 2'h1
`define UHPIA_OP_PWRDN 2'h3
`define UHPIA_LINE_J 2'h1
`define UHPIA_LINE_K 2'h2

// ==========================================
// Timing at 20 MHz, period in ns
`define UHPIA_CLK_NS 50
`define UHPIA_CANCEL_CYC 6
`define UHPIA_SETTLE_MS 100
`define UHPIA_DEBOUNCE_MS 100
`define UHPIA_ATTACH_NS 2500
// Settle and debounce add one to the quotient to be strictly longer; attach only rounds up
`define UHPIA_SETTLE_CYC ((`UHPIA_SETTLE_MS * 1000000) / `UHPIA_CLK_NS + 1)
`define UHPIA_DEBOUNCE_CYC ((`UHPIA_DEBOUNCE_MS * 1000000) / `UHPIA_CLK_NS + 1)
`define UHPIA_ATTACH_CYC ((`UHPIA_ATTACH_NS + `UHPIA_CLK_NS - 1) / `UHPIA_CLK_NS)
`define UHPIA_CNT_W 22

// ==========================================
// Event bits
`define UHPIA_EV_CON 0
`define UHPIA_EV_CANCEL 1
`define UHPIA_EV_W 2

`endif

// ===== rtl/uhpia_timer.v
// Down counter used for settle, debounce and line hold times
`timescale 1ns/1ps
`include "uhpia_defs.vh"

module uhpia_timer (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Control
    input wire load,
    input wire [`UHPIA_CNT_W-1:0] load_val,
    input wire run,
    // Status
    output wire done
);

reg [`UHPIA_CNT_W-1:0] cnt_ff;

always @(posedge mclk) begin
    if (!rst_n) begin
        cnt_ff <= {`UHPIA_CNT_W{1'b0}};
    end else if (load) begin
        cnt_ff <= load_val;
    end else if (run && cnt_ff != {`UHPIA_CNT_W{1'b0}}) begin
        cnt_ff <= cnt_ff - 1'b1;
    end
end

assign done = (cnt_ff == {`UHPIA_CNT_W{1'b0}}) && !load;

endmodule

// ===== rtl/uhpia_events.v
// Sticky event status with enable, write-one clear and interrupt
`timescale 1ns/1ps
`include "uhpia_defs.vh"

module uhpia_events (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Event sources
    input wire [`UHPIA_EV_W-1:0] ev_set,
    // Register access
    input wire en_wr,
    input wire clr_wr,
    input wire [`UHPIA_EV_W-1:0] wdata,
    // State
    output reg [`UHPIA_EV_W-1:0] stat_ff,
    output reg [`UHPIA_EV_W-1:0] en_ff,
    output reg irq_ff
);

wire [`UHPIA_EV_W-1:0] nxt_stat;

genvar gi;
generate
    for (gi = 0; gi < `UHPIA_EV_W; gi = gi + 1) begin : g_bit
        // Set wins over a clear in the same cycle
        assign nxt_stat[gi] = ev_set[gi] | (stat_ff[gi] & ~(clr_wr & wdata[gi]));
    end
endgenerate

always @(posedge mclk) begin
    if (!rst_n) begin
        stat_ff <= {`UHPIA_EV_W{1'b0}};
        en_ff <= {`UHPIA_EV_W{1'b0}};
        irq_ff <= 1'b0;
    end else begin
        stat_ff <= nxt_stat;
        if (en_wr) begin
            en_ff <= wdata;
        end
        irq_ff <= |(nxt_stat & (en_wr ? wdata : en_ff));
    end
end

endmodule

// ===== rtl/uhpia_top.v
// Host port sequencer for the go-idle and wait-for-attach commands
`timescale 1ns/1ps
`include "uhpia_defs.vh"

module uhpia_top #(
    parameter [`UHPIA_CMD_FIELD_W-1:0] CMD_GO_WAIT = `UHPIA_CMD_GO_WAIT_DEF,
    parameter [`UHPIA_CNT_W-1:0] SETTLE_CYC = `UHPIA_SETTLE_CYC,
    parameter [`UHPIA_CNT_W-1:0] DEBOUNCE_CYC = `UHPIA_DEBOUNCE_CYC
) (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Register port
    input wire [`UHPIA_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    // Transceiver
    input wire [1:0] line_state_code,
    output reg [1:0] transceiver_speed_select,
    output reg termination_select,
    output reg [1:0] transceiver_operating_mode,
    output reg [1:0] port_speed_setting,
    // Port power and engine control
    output reg bus_power_enable,
    output reg transaction_enable,
    output reg connect_detect_en,
    output reg disconnect_detect_en,
    output reg wakeup_detect_en,
    output reg chirp_detect_en,
    // Interrupt
    output wire irq
);

// ==========================================
// States
localparam [6:0] ST_IDLE = 7'h01;
localparam [6:0] ST_CANCEL = 7'h02;
localparam [6:0] ST_SETTLE = 7'h04;
localparam [6:0] ST_LINE = 7'h08;
localparam [6:0] ST_DEBOUNCE = 7'h10;
localparam [6:0] ST_DONE = 7'h20;
localparam [6:0] ST_HOLD = 7'h40;

localparam [`UHPIA_CNT_W-1:0] ATTACH_CYC = `UHPIA_ATTACH_CYC;
localparam [`UHPIA_CNT_W-1:0] CANCEL_CYC = `UHPIA_CANCEL_CYC;

reg [6:0] state_ff;
reg [6:0] nxt_state;
reg cancel_ff;
reg [`UHPIA_CMD_FIELD_W-1:0] cmd_ff;
reg [2:0] mon_ff;
reg low_speed_ff;
reg [1:0] held_line_ff;

// ==========================================
// Register decode
wire wr_cmd = reg_wr && reg_addr == `UHPIA_A_CMD;
wire wr_en = reg_wr && reg_addr == `UHPIA_A_EVT_EN;
wire wr_clr = reg_wr && reg_addr == `UHPIA_A_EVT_CLR;
wire [`UHPIA_CMD_FIELD_W-1:0] wr_field = reg_wdata[`UHPIA_CMD_FIELD_W-1:0];
wire wr_cancel = wr_cmd && reg_wdata[`UHPIA_CMD_CANCEL_BIT];
// Go-idle is refused while the cancel bit still stands
wire go_idle = wr_cmd && !wr_cancel && !cancel_ff && wr_field == `UHPIA_CMD_GO_IDLE;
wire go_wait = wr_cmd && !wr_cancel && !cancel_ff && wr_field == CMD_GO_WAIT;

// ==========================================
// Timers
reg long_load;
reg [`UHPIA_CNT_W-1:0] long_val;
reg line_load;
wire long_done;
wire line_done;
wire line_attach = line_state_code == `UHPIA_LINE_J || line_state_code == `UHPIA_LINE_K;

uhpia_timer u_long (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(long_load),
    .load_val(long_val),
    .run(1'b1),
    .done(long_done)
);

// Restarts whenever the line leaves the level being timed
uhpia_timer u_line (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(line_load),
    .load_val(ATTACH_CYC),
    .run(1'b1),
    .done(line_done)
);

// ==========================================
// Events
wire [`UHPIA_EV_W-1:0] ev_stat;
wire [`UHPIA_EV_W-1:0] ev_en;
reg [`UHPIA_EV_W-1:0] ev_set;

uhpia_events u_ev (
    .mclk(mclk),
    .rst_n(rst_n),
    .ev_set(ev_set),
    .en_wr(wr_en),
    .clr_wr(wr_clr),
    .wdata(reg_wdata[`UHPIA_EV_W-1:0]),
    .stat_ff(ev_stat),
    .en_ff(ev_en),
    .irq_ff(irq)
);

// ==========================================
// Sequencer
always @* begin
    nxt_state = state_ff;
    long_load = 1'b0;
    long_val = SETTLE_CYC;
    line_load = 1'b0;
    ev_set = {`UHPIA_EV_W{1'b0}};
    if (state_ff != ST_LINE || line_state_code != held_line_ff || !line_attach) begin
        line_load = 1'b1;
    end
    if (wr_cancel) begin
        nxt_state = ST_CANCEL;
        long_load = 1'b1;
        long_val = CANCEL_CYC;
    end else if (go_idle) begin
        nxt_state = ST_IDLE;
    end else if (go_wait) begin
        nxt_state = ST_SETTLE;
        long_load = 1'b1;
        long_val = SETTLE_CYC;
    end else begin
        case (state_ff)
            ST_CANCEL: begin
                if (long_done) begin
                    nxt_state = ST_HOLD;
                    ev_set[`UHPIA_EV_CANCEL] = 1'b1;
                end
            end
            ST_SETTLE: begin
                if (long_done) begin
                    nxt_state = ST_LINE;
                end
            end
            ST_LINE: begin
                // J or K held long enough; high-speed devices show J here
                if (line_done && line_attach) begin
                    nxt_state = ST_DEBOUNCE;
                    long_load = 1'b1;
                    long_val = DEBOUNCE_CYC;
                end
            end
            ST_DEBOUNCE: begin
                // After low-speed switch the line shows J again
                if (line_state_code != `UHPIA_LINE_J) begin
                    nxt_state = ST_LINE;
                end else if (long_done) begin
                    nxt_state = ST_DONE;
                    ev_set[`UHPIA_EV_CON] = 1'b1;
                end
            end
            ST_IDLE, ST_DONE, ST_HOLD: begin
                nxt_state = state_ff;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end
end

always @(posedge mclk) begin
    if (!rst_n) begin
        state_ff <= ST_IDLE;
        cancel_ff <= 1'b0;
        cmd_ff <= `UHPIA_CMD_NONE;
        mon_ff <= `UHPIA_MON_IDLE;
        low_speed_ff <= 1'b0;
        held_line_ff <= 2'h0;
        bus_power_enable <= 1'b0;
        transceiver_speed_select <= `UHPIA_SEL_FS;
        termination_select <= 1'b1;
        transceiver_operating_mode <= `UHPIA_OP_NONDRV;
        port_speed_setting <= `UHPIA_SEL_FS;
        transaction_enable <= 1'b0;
        connect_detect_en <= 1'b0;
        disconnect_detect_en <= 1'b0;
        wakeup_detect_en <= 1'b0;
        chirp_detect_en <= 1'b0;
    end else begin
        state_ff <= nxt_state;
        held_line_ff <= line_state_code;
        if (wr_cancel) begin
            cancel_ff <= 1'b1;
            cmd_ff <= `UHPIA_CMD_NONE;
        end else if (state_ff == ST_CANCEL && long_done) begin
            // Seven cycles pass before clear, so idle lands past six
            cancel_ff <= 1'b0;
        end
        if (go_idle) begin
            cmd_ff <= wr_field;
            mon_ff <= `UHPIA_MON_IDLE;
            bus_power_enable <= 1'b0;
            transceiver_speed_select <= `UHPIA_SEL_FS;
            termination_select <= 1'b1;
            transceiver_operating_mode <= `UHPIA_OP_NONDRV;
            transaction_enable <= 1'b0;
            connect_detect_en <= 1'b0;
            disconnect_detect_en <= 1'b0;
            wakeup_detect_en <= 1'b0;
            chirp_detect_en <= 1'b0;
        end else if (go_wait) begin
            cmd_ff <= wr_field;
            mon_ff <= `UHPIA_MON_WAIT;
            bus_power_enable <= 1'b1;
            transceiver_speed_select <= `UHPIA_SEL_FS;
            termination_select <= 1'b1;
            transceiver_operating_mode <= `UHPIA_OP_PWRDN;
            port_speed_setting <= `UHPIA_SEL_FS;
            low_speed_ff <= 1'b0;
            connect_detect_en <= 1'b0;
            disconnect_detect_en <= 1'b0;
        end else if (!wr_cancel) begin
            if (state_ff == ST_SETTLE && nxt_state == ST_LINE) begin
                connect_detect_en <= 1'b1;
            end
            if (state_ff == ST_LINE && nxt_state == ST_DEBOUNCE) begin
                disconnect_detect_en <= 1'b1;
                if (line_state_code == `UHPIA_LINE_K) begin
                    low_speed_ff <= 1'b1;
                    transceiver_speed_select <= `UHPIA_SEL_LS;
                    port_speed_setting <= `UHPIA_SEL_LS;
                end
            end
            if (state_ff == ST_DEBOUNCE && nxt_state == ST_LINE) begin
                disconnect_detect_en <= 1'b0;
                low_speed_ff <= 1'b0;
                transceiver_speed_select <= `UHPIA_SEL_FS;
                port_speed_setting <= `UHPIA_SEL_FS;
            end
            if (nxt_state == ST_DONE && state_ff == ST_DEBOUNCE) begin
                connect_detect_en <= 1'b0;
                disconnect_detect_en <= 1'b0;
            end
        end
    end
end

// ==========================================
// Read path, one cycle latency
always @(posedge mclk) begin
    if (!rst_n) begin
        reg_rdata <= 8'h00;
    end else if (reg_rd) begin
        case (reg_addr)
            `UHPIA_A_CMD: reg_rdata <= {cancel_ff, 3'h0, cmd_ff};
            `UHPIA_A_MON: reg_rdata <= {low_speed_ff, state_ff};
            `UHPIA_A_XCVR: reg_rdata <= {transceiver_operating_mode, termination_select,
                port_speed_setting, 1'b0, transceiver_speed_select};
            `UHPIA_A_EVT: reg_rdata <= {6'h00, ev_stat};
            `UHPIA_A_EVT_EN: reg_rdata <= {6'h00, ev_en};
            default: reg_rdata <= 8'h00;
        endcase
    end else begin
        reg_rdata <= 8'h00;
    end
end

endmodule

// ===== verif/uhpia_top_props.sv
// Checker for the host port sequencer
`timescale 1ns/1ps
`include "uhpia_defs.vh"
module uhpia_top_props #(
    parameter [`UHPIA_CNT_W-1:0] SETTLE_CYC = 200,
    parameter [`UHPIA_CNT_W-1:0] DEBOUNCE_CYC = 200
) (
    // Clock and reset
    input wire mclk,
    input wire rst_n,
    // Register port
    input wire [`UHPIA_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // Transceiver
    input wire [1:0] line_state_code,
    input wire [1:0] transceiver_speed_select,
    input wire termination_select,
    input wire [1:0] transceiver_operating_mode,
    input wire [1:0] port_speed_setting,
    // Power and detectors
    input wire bus_power_enable,
    input wire transaction_enable,
    input wire connect_detect_en,
    input wire disconnect_detect_en,
    input wire wakeup_detect_en,
    input wire chirp_detect_en,
    input wire irq
);
    localparam int S_LO = SETTLE_CYC - 1;
    logic [7:0] hold_ff;
    logic [1:0] line_ff;
    logic [`UHPIA_CNT_W-1:0] deb_ff;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Helper counters
    always @(posedge mclk) begin
        line_ff <= line_state_code;
        if (!rst_n || line_state_code == 2'h0 || line_state_code != line_ff) begin
            hold_ff <= 8'h00;
        end else if (hold_ff != 8'hFF) begin
            hold_ff <= hold_ff + 8'h01;
        end
        deb_ff <= (!rst_n || !disconnect_detect_en) ? '0 : deb_ff + 1'b1;
    end
    // ==========================================
    // Properties
    a_idle_outputs: assert property ($fell(bus_power_enable) |->
        transceiver_operating_mode == `UHPIA_OP_NONDRV && termination_select &&
        transceiver_speed_select == `UHPIA_SEL_FS && !transaction_enable &&
        !connect_detect_en && !disconnect_detect_en && !wakeup_detect_en && !chirp_detect_en)
        else $error("idle entry outputs wrong");
    a_wait_outputs: assert property ($rose(bus_power_enable) |->
        transceiver_operating_mode == `UHPIA_OP_PWRDN && termination_select &&
        transceiver_speed_select == `UHPIA_SEL_FS && port_speed_setting == `UHPIA_SEL_FS)
        else $error("wait entry outputs wrong");
    a_settle_delay: assert property ($rose(bus_power_enable) |->
        ##S_LO !connect_detect_en ##[1:5] connect_detect_en)
        else $error("connect detect enabled at wrong time");
    a_attach_hold: assert property ($rose(disconnect_detect_en) |-> hold_ff >= 8'h2F)
        else $error("attach taken without steady line");
    a_ls_switch: assert property ($rose(disconnect_detect_en) |->
        ((transceiver_speed_select == `UHPIA_SEL_LS) == ($past(line_state_code) == `UHPIA_LINE_K))
        && port_speed_setting == transceiver_speed_select)
        else $error("attach speed wrong");
    a_debounce_abort: assert property (disconnect_detect_en &&
        line_state_code != `UHPIA_LINE_J |=> !disconnect_detect_en &&
        transceiver_speed_select == `UHPIA_SEL_FS && port_speed_setting == `UHPIA_SEL_FS)
        else $error("debounce abort wrong");
    a_debounce_len: assert property ($fell(disconnect_detect_en) && !connect_detect_en &&
        bus_power_enable |-> deb_ff >= DEBOUNCE_CYC - 1)
        else $error("debounce too short");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    c_ls_attach: cover property ($rose(disconnect_detect_en) && port_speed_setting == 2'h2);
    c_attached: cover property ($fell(disconnect_detect_en) && !connect_detect_en);
    c_abort: cover property ($fell(disconnect_detect_en) && connect_detect_en);
endmodule

// ===== verif/uhpia_dev_model.sv
// Transceiver line state with an attached device
`timescale 1ns/1ps
`include "uhpia_defs.vh"
module uhpia_dev_model (
    // Port power and speed
    input wire bus_power_enable,
    input wire [1:0] transceiver_speed_select,
    // Device kind: 0 none, 1 full or high speed, 2 low speed
    input wire [1:0] dev_kind,
    // Line state
    output wire [1:0] line_state_code
);
    // Pull-downs give SE0 with no device or no power
    assign line_state_code = (!bus_power_enable || dev_kind == 2'h0) ? 2'h0 :
        (dev_kind == 2'h2 && transceiver_speed_select != `UHPIA_SEL_LS) ? `UHPIA_LINE_K :
        `UHPIA_LINE_J;
endmodule

// ===== verif/usb_host_port_idle_attach_tb_top.sv
// Testbench for the host port idle and attach sequencer
`timescale 1ns/1ps
`include "uhpia_defs.vh"
module usb_host_port_idle_attach_tb_top;
    // ==========================================
    // Signals
    localparam int SETTLE = 200;
    localparam int DEBOUNCE = 200;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [1:0] dev_kind = 2'h0;
    logic [7:0] reg_rdata;
    logic [1:0] line_state_code, transceiver_speed_select;
    logic [1:0] transceiver_operating_mode, port_speed_setting;
    logic termination_select, bus_power_enable, transaction_enable, connect_detect_en;
    logic disconnect_detect_en, wakeup_detect_en, chirp_detect_en, irq;
    int miscompares = 0;
    int num_checks = 0;
    int n;
    initial begin
        forever #25 mclk = ~mclk;
    end
    uhpia_top #(.SETTLE_CYC(SETTLE), .DEBOUNCE_CYC(DEBOUNCE)) dut_u (.*);
    uhpia_dev_model dev_u (.*);
    // ==========================================
    // Shared tasks
    function automatic logic [7:0] pins();
        return {bus_power_enable, transceiver_operating_mode, termination_select,
            port_speed_setting, transceiver_speed_select};
    endfunction
    function automatic logic [4:0] det();
        return {transaction_enable, connect_detect_en, disconnect_detect_en,
            wakeup_detect_en, chirp_detect_en};
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk("rdata", reg_rdata & m, e);
    endtask
    // Bounded so a stuck sequence cannot hang the run
    task automatic wt(ref logic s, input logic v);
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (s !== v && n < 5000);
        chk("wait", s, v);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset();
        @(negedge mclk);
        chk("pins", pins(), 8'h35);
        chk("det", det(), 5'h00);
        rd(`UHPIA_A_MON, 8'hFF, 8'h01);
        rd(`UHPIA_A_XCVR, 8'hFF, 8'h69);
        rd(`UHPIA_A_EVT, 8'hFF, 8'h00);
        rd(4'hF, 8'hFF, 8'h00);
    endtask
    task automatic t_fs_attach();
        dev_kind <= 2'h1;
        wr(`UHPIA_A_EVT_EN, 8'h01);
        wr(`UHPIA_A_CMD, 8'h03);
        @(negedge mclk);
        chk("pins", pins(), 8'hF5);
        wt(connect_detect_en, 1'b1);
        chk("settle", n > SETTLE, 1'b1);
        wt(disconnect_detect_en, 1'b1);
        chk("pins", pins(), 8'hF5);
        wt(disconnect_detect_en, 1'b0);
        chk("debounce", n >= DEBOUNCE, 1'b1);
        chk("det", det(), 5'h00);
        chk("irq", irq, 1'b1);
        rd(`UHPIA_A_EVT, 8'h01, 8'h01);
        wr(`UHPIA_A_EVT_CLR, 8'h01);
        @(negedge mclk);
        chk("irq", irq, 1'b0);
        rd(`UHPIA_A_EVT, 8'h01, 8'h00);
    endtask
    task automatic t_idle();
        wr(`UHPIA_A_CMD, 8'h80);
        wr(`UHPIA_A_CMD, 8'h01);
        rd(`UHPIA_A_CMD, 8'h80, 8'h80);
        rd(`UHPIA_A_MON, 8'h01, 8'h00);
        repeat (6) @(posedge mclk);
        rd(`UHPIA_A_CMD, 8'hFF, 8'h00);
        rd(`UHPIA_A_EVT, 8'h02, 8'h02);
        wr(`UHPIA_A_CMD, 8'h01);
        @(negedge mclk);
        chk("pins", pins(), 8'h35);
        chk("det", det(), 5'h00);
        rd(`UHPIA_A_MON, 8'hFF, 8'h01);
        wr(`UHPIA_A_EVT_CLR, 8'h02);
    endtask
    task automatic t_ls_abort();
        dev_kind <= 2'h2;
        wr(`UHPIA_A_EVT_EN, 8'h00);
        wr(`UHPIA_A_CMD, 8'h03);
        wt(disconnect_detect_en, 1'b1);
        chk("pins", pins(), 8'hFA);
        repeat (20) @(posedge mclk);
        dev_kind <= 2'h0;
        wt(disconnect_detect_en, 1'b0);
        chk("pins", pins(), 8'hF5);
        chk("con", connect_detect_en, 1'b1);
        rd(`UHPIA_A_EVT, 8'h01, 8'h00);
        dev_kind <= 2'h2;
        wt(disconnect_detect_en, 1'b1);
        wt(disconnect_detect_en, 1'b0);
        chk("debounce", n >= DEBOUNCE, 1'b1);
        chk("pins", pins(), 8'hFA);
        chk("det", det(), 5'h00);
        chk("irq", irq, 1'b0);
        rd(`UHPIA_A_EVT, 8'h01, 8'h01);
    endtask
    // ==========================================
    // Sequence and verdict
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_fs_attach();
        t_idle();
        t_ls_abort();
        stop_test();
    end
    initial begin
        #(20000 * 50);
        miscompares++;
        stop_test();
    end
endmodule
bind uhpia_top uhpia_top_props #(.SETTLE_CYC(SETTLE_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC)) prp_u (.*);
